// ===== src/edc_map.svh
// register offsets, reset values, field positions and message codes of the error capture
`ifndef EDC_MAP_SVH
`define EDC_MAP_SVH

// ------------------------------------------------------------
// register word offsets
// ------------------------------------------------------------
`define EDC_OFS_TO_HI     20'hEF044
`define EDC_OFS_TO_LO     20'hEF045
`define EDC_OFS_PE_HI     20'hEF046
`define EDC_OFS_PE_LO     20'hEF047
`define EDC_OFS_CODE      20'hEF04B
`define EDC_OFS_PARAM1    20'hEF04C
`define EDC_OFS_PARAM2    20'hEF04D
`define EDC_OFS_PARAM3    20'hEF04E
`define EDC_OFS_STATUS    20'hEF050
`define EDC_OFS_CTRL      20'hEF051

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define EDC_RST_WORD      16'h0000
`define EDC_RST_CTRL      2'h3

// ------------------------------------------------------------
// control and status fields
// ------------------------------------------------------------
`define EDC_CTRL_MSG_EN   0
`define EDC_CTRL_ADDR_EN  1
`define EDC_ST_CLASS_LSB  0
`define EDC_ST_UNKNOWN    4
`define EDC_ST_TO_SEEN    8
`define EDC_ST_PE_SEEN    9
`define EDC_ST_MSG_VALID  10

// ------------------------------------------------------------
// message codes and ranges
// ------------------------------------------------------------
`define EDC_NUM_USER_MIN  8'h01
`define EDC_NUM_USER_MAX  8'h2F
`define EDC_NUM_CFG_MIN   8'h30
`define EDC_NUM_CFG_MAX   8'h3F
`define EDC_NUM_SYSTEM    8'h40
`define EDC_NUM_TEST_MIN  8'h61
`define EDC_NUM_TEST_MAX  8'h68
`define EDC_NUM_USER_TO   8'h06
`define EDC_NUM_USER_PE   8'h11
`define EDC_PT_NONE       8'h00
`define EDC_PT_ADDR       8'h03
`define EDC_PT_MAX        8'h10

`endif

// ===== src/edc_pkg.sv
// types shared by the error capture modules
package edc_pkg;

   // error number class
   typedef enum logic [2:0] {
      EDC_CLASS_NONE   = 3'h0,
      EDC_CLASS_USER   = 3'h1,
      EDC_CLASS_CFG    = 3'h2,
      EDC_CLASS_SYSTEM = 3'h3,
      EDC_CLASS_TEST   = 3'h4
   } edc_class_e;

   // one four-word message
   typedef struct packed {
      logic [7:0]  number;
      logic [7:0]  ptype;
      logic [15:0] param1;
      logic [15:0] param2;
      logic [15:0] param3;
   } edc_msg_s;

endpackage

// ===== src/edc_code_if.sv
// lookup path between capture logic and code table
`timescale 1ns/1ps
interface edc_code_if;
   logic [7:0]          number;
   logic [7:0]          ptype;
   edc_pkg::edc_class_e err_class;
   logic                known;

   modport lookup (output number, input ptype, input err_class, input known);
   modport table_side (input number, output ptype, output err_class, output known);
endinterface

// ===== src/edc_code_table.sv
// error number to parameter type and class lookup
`timescale 1ns/1ps
`include "edc_map.svh"
module edc_code_table (
   // lookup
   edc_code_if.table_side io_code
);

   // ------------------------------------------------------------
   // class by number range
   // ------------------------------------------------------------
   always_comb begin
      // RL5 range classes
      if (io_code.number >= `EDC_NUM_USER_MIN && io_code.number <= `EDC_NUM_USER_MAX) begin
         io_code.err_class = edc_pkg::EDC_CLASS_USER;
      end else if (io_code.number >= `EDC_NUM_CFG_MIN && io_code.number <= `EDC_NUM_CFG_MAX) begin
         io_code.err_class = edc_pkg::EDC_CLASS_CFG;
      end else if (io_code.number == `EDC_NUM_SYSTEM) begin
         io_code.err_class = edc_pkg::EDC_CLASS_SYSTEM;
      end else if (io_code.number >= `EDC_NUM_TEST_MIN && io_code.number <= `EDC_NUM_TEST_MAX) begin
         io_code.err_class = edc_pkg::EDC_CLASS_TEST;
      end else begin
         io_code.err_class = edc_pkg::EDC_CLASS_NONE;
      end
   end

   // ------------------------------------------------------------
   // parameter type table
   // ------------------------------------------------------------
   always_comb begin
      io_code.known = 1'b1;
      case (io_code.number)
         // RL8 RL13 program faults and stops
         8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h08, 8'h12, 8'h13, 8'h14, 8'h15,
         8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1F, 8'h27, 8'h28:
            io_code.ptype = 8'h01;
         // RL9 peripheral timeout
         8'h05: io_code.ptype = 8'h02;
         // RL10 address carrying faults
         8'h06, 8'h0B, 8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h11:
            io_code.ptype = `EDC_PT_ADDR;
         // RL11 missing data block
         8'h09: io_code.ptype = 8'h04;
         // RL12 interrupt faults
         8'h0A, 8'h23: io_code.ptype = 8'h05;
         // RL21 RL17 RL18 image update, extended and io config
         8'h0D, 8'h35, 8'h36, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h3E:
            io_code.ptype = 8'h07;
         // RL14 initialization faults
         8'h1C, 8'h1D, 8'h29: io_code.ptype = 8'h08;
         // RL15 RL17 RL20 no parameter
         8'h1E, 8'h24, 8'h25, 8'h26, 8'h30, 8'h32, 8'h33, 8'h40, 8'h66, 8'h67, 8'h68:
            io_code.ptype = `EDC_PT_NONE;
         // RL16 block creation failures
         8'h20, 8'h21, 8'h22: io_code.ptype = 8'h09;
         // RL17 RL18 header faults
         8'h34, 8'h38, 8'h39: io_code.ptype = 8'h06;
         // RL19 self test codes
         8'h61, 8'h63: io_code.ptype = 8'h0B;
         8'h62: io_code.ptype = 8'h0A;
         8'h64, 8'h65: io_code.ptype = 8'h0C;
         default: begin
            io_code.ptype = `EDC_PT_NONE;
            io_code.known = 1'b0;
         end
      endcase
   end

endmodule // edc_code_table

// ===== src/edc_capture.sv
// error diagnostic capture: fault addresses and last error message of any class
// Operation
// RL1: timeout address stored high then low
// RL2: parity address stored high then low
// RL3: message always holds latest error; here a non-user bus timeout leaves the message unchanged
// RL4: code word: number high, type low
// RL5: number ranges give user, config, system
// RL6: parameter type 00H..10H selects layout
// RL7: three parameter words follow code word
// RL8: program faults use parameter type 01H
// RL9: peripheral timeout is 05H, type 02H
// RL10: memory timeout 06H, parity 11H, type 03H
// RL11: missing data block is 09H, type 04H
// RL12: interrupt faults 0AH, 23H, type 05H
// RL13: stop causes use parameter type 01H
// RL14: init timeout or parity 1CH, 08H
// RL15: start-up refusals use parameter type 00H
// RL16: block creation failures use type 09H
// RL17: extended config errors 30H to 36H
// RL18: io config errors 38H to 3EH
// RL19: self test 61H, 63H, type 0BH
// RL20: self test 66H..68H, type 00H
// RL21: image update timeout 0DH, type 07H
// RL22: all four words update together
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "edc_map.svh"
module edc_capture #(
   parameter int AW = 20
) (
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_nrst,
   // register port
   input  wire logic [AW-1:0] i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   // general error report
   input  wire logic        i_err_valid,
   input  wire logic [7:0]  i_err_number,
   input  wire logic [15:0] i_err_param1,
   input  wire logic [15:0] i_err_param2,
   input  wire logic [15:0] i_err_param3,
   // bus timeout
   input  wire logic        i_bus_timeout_error,
   input  wire logic        i_bus_timeout_user,
   input  wire logic [31:0] i_bus_timeout_addr,
   // memory parity
   input  wire logic        i_memory_parity_error,
   input  wire logic [31:0] i_parity_addr,
   // status
   output logic             o_msg_update,
   output logic      [2:0]  o_last_class
);

   // ------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------
   if (AW < 20) begin : g_bad_aw
      $error("address width too small for register map");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0]         to_hi;
      logic [15:0]         to_lo;
      logic [15:0]         pe_hi;
      logic [15:0]         pe_lo;
      edc_pkg::edc_msg_s   msg;
      edc_pkg::edc_class_e last_class;
      logic                unknown;
      logic                to_seen;
      logic                pe_seen;
      logic                msg_valid;
      logic [1:0]          ctrl;
      logic [15:0]         rdata;
      logic                update;
   } edc_state_s;

   edc_state_s state_ff;
   edc_state_s nxt_state;

   edc_code_if code_bus ();
   edc_code_table u_table (
      .io_code (code_bus)
   );

   logic [AW-1:0] word_addr;
   logic          msg_en;
   logic          addr_en;
   logic          any_msg;
   logic [15:0]   status_word;

   assign word_addr = i_addr;
   assign msg_en    = state_ff.ctrl[`EDC_CTRL_MSG_EN];
   assign addr_en   = state_ff.ctrl[`EDC_CTRL_ADDR_EN];
   assign any_msg   = msg_en & (i_err_valid | i_bus_timeout_error | i_memory_parity_error);
   assign code_bus.number = i_err_number;

   always_comb begin
      status_word = 16'h0000;
      status_word[`EDC_ST_CLASS_LSB +: 3] = state_ff.last_class;
      status_word[`EDC_ST_UNKNOWN]   = state_ff.unknown;
      status_word[`EDC_ST_TO_SEEN]   = state_ff.to_seen;
      status_word[`EDC_ST_PE_SEEN]   = state_ff.pe_seen;
      status_word[`EDC_ST_MSG_VALID] = state_ff.msg_valid;
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_state.update = 1'b0;

      // software clears seen flags by writing ones; a new event wins
      if (i_wr && word_addr == AW'(`EDC_OFS_STATUS)) begin
         if (i_wdata[`EDC_ST_TO_SEEN]) begin
            nxt_state.to_seen = 1'b0;
         end
         if (i_wdata[`EDC_ST_PE_SEEN]) begin
            nxt_state.pe_seen = 1'b0;
         end
         if (i_wdata[`EDC_ST_MSG_VALID]) begin
            nxt_state.msg_valid = 1'b0;
         end
      end
      if (i_wr && word_addr == AW'(`EDC_OFS_CTRL)) begin
         nxt_state.ctrl = i_wdata[1:0];
      end

      // RL1 timeout address capture
      if (i_bus_timeout_error && addr_en) begin
         nxt_state.to_hi   = i_bus_timeout_addr[31:16];
         nxt_state.to_lo   = i_bus_timeout_addr[15:0];
         nxt_state.to_seen = 1'b1;
      end
      // RL2 parity address capture
      if (i_memory_parity_error && addr_en) begin
         nxt_state.pe_hi   = i_parity_addr[31:16];
         nxt_state.pe_lo   = i_parity_addr[15:0];
         nxt_state.pe_seen = 1'b1;
      end

      // RL3 RL22 whole message replaced at once
      // parity outranks a user timeout, which outranks a reported error
      if (any_msg) begin
         nxt_state.update    = 1'b1;
         if (i_memory_parity_error) begin
            // RL10 parity message with address
            nxt_state.msg.number = `EDC_NUM_USER_PE;
            nxt_state.msg.ptype  = `EDC_PT_ADDR;
            nxt_state.msg.param1 = `EDC_RST_WORD;
            nxt_state.msg.param2 = i_parity_addr[31:16];
            nxt_state.msg.param3 = i_parity_addr[15:0];
            nxt_state.last_class = edc_pkg::EDC_CLASS_USER;
            nxt_state.unknown    = 1'b0;
         end else if (i_bus_timeout_error && i_bus_timeout_user) begin
            // RL10 memory timeout message with address
            nxt_state.msg.number = `EDC_NUM_USER_TO;
            nxt_state.msg.ptype  = `EDC_PT_ADDR;
            nxt_state.msg.param1 = `EDC_RST_WORD;
            nxt_state.msg.param2 = i_bus_timeout_addr[31:16];
            nxt_state.msg.param3 = i_bus_timeout_addr[15:0];
            nxt_state.last_class = edc_pkg::EDC_CLASS_USER;
            nxt_state.unknown    = 1'b0;
         end else if (i_err_valid) begin
            // RL4 RL6 RL7 number and looked-up type
            nxt_state.msg.number = i_err_number;
            nxt_state.msg.ptype  = code_bus.ptype;
            nxt_state.last_class = code_bus.err_class;
            nxt_state.unknown    = ~code_bus.known;
            // type 00H carries no parameters
            if (code_bus.ptype == `EDC_PT_NONE) begin
               nxt_state.msg.param1 = `EDC_RST_WORD;
               nxt_state.msg.param2 = `EDC_RST_WORD;
               nxt_state.msg.param3 = `EDC_RST_WORD;
            end else begin
               nxt_state.msg.param1 = i_err_param1;
               nxt_state.msg.param2 = i_err_param2;
               nxt_state.msg.param3 = i_err_param3;
            end
         end else begin
            // non-user timeout only keeps its address
            nxt_state.update    = 1'b0;
         end
      end
      // set after the software clear so a new message wins
      if (nxt_state.update) begin
         nxt_state.msg_valid = 1'b1;
      end

      // RL7 register read, one cycle latency
      nxt_state.rdata = `EDC_RST_WORD;
      if (i_rd) begin
         case (word_addr)
            AW'(`EDC_OFS_TO_HI):  nxt_state.rdata = state_ff.to_hi;
            AW'(`EDC_OFS_TO_LO):  nxt_state.rdata = state_ff.to_lo;
            AW'(`EDC_OFS_PE_HI):  nxt_state.rdata = state_ff.pe_hi;
            AW'(`EDC_OFS_PE_LO):  nxt_state.rdata = state_ff.pe_lo;
            AW'(`EDC_OFS_CODE):   nxt_state.rdata = {state_ff.msg.number, state_ff.msg.ptype};
            AW'(`EDC_OFS_PARAM1): nxt_state.rdata = state_ff.msg.param1;
            AW'(`EDC_OFS_PARAM2): nxt_state.rdata = state_ff.msg.param2;
            AW'(`EDC_OFS_PARAM3): nxt_state.rdata = state_ff.msg.param3;
            AW'(`EDC_OFS_STATUS): nxt_state.rdata = status_word;
            AW'(`EDC_OFS_CTRL):   nxt_state.rdata = {14'h0000, state_ff.ctrl};
            default:              nxt_state.rdata = `EDC_RST_WORD;
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         state_ff            <= '0;
         state_ff.last_class <= edc_pkg::EDC_CLASS_NONE;
         state_ff.ctrl       <= `EDC_RST_CTRL;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign o_rdata      = state_ff.rdata;
   assign o_msg_update = state_ff.update;
   assign o_last_class = state_ff.last_class;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   chk_timeout_addr: assert property ( // RL1
      i_bus_timeout_error && addr_en |=>
         state_ff.to_hi == $past(i_bus_timeout_addr[31:16]) &&
         state_ff.to_lo == $past(i_bus_timeout_addr[15:0]))
      else $error("timeout address not captured");

   chk_parity_addr: assert property ( // RL2
      i_memory_parity_error && addr_en |=>
         state_ff.pe_hi == $past(i_parity_addr[31:16]) &&
         state_ff.pe_lo == $past(i_parity_addr[15:0]) && state_ff.pe_seen)
      else $error("parity address not captured");

   chk_parity_msg: assert property ( // RL10
      i_memory_parity_error && msg_en |=>
         state_ff.msg.number == `EDC_NUM_USER_PE && state_ff.msg.ptype == `EDC_PT_ADDR &&
         state_ff.msg.param3 == $past(i_parity_addr[15:0]))
      else $error("parity message wrong");

   chk_user_timeout_msg: assert property ( // RL10
      i_bus_timeout_error && i_bus_timeout_user && msg_en && !i_memory_parity_error |=>
         state_ff.msg.number == `EDC_NUM_USER_TO && o_msg_update)
      else $error("user memory timeout message wrong");

   chk_latest_msg: assert property ( // RL3
      i_err_valid && msg_en && !i_bus_timeout_error && !i_memory_parity_error |=>
         state_ff.msg.number == $past(i_err_number))
      else $error("message does not hold latest error");

   chk_class_user: assert property ( // RL5
      o_msg_update && state_ff.msg.number >= `EDC_NUM_USER_MIN &&
         state_ff.msg.number <= `EDC_NUM_USER_MAX |-> o_last_class == edc_pkg::EDC_CLASS_USER)
      else $error("user class not reported");

   chk_ptype_range: assert property ( // RL6
      state_ff.msg.ptype <= `EDC_PT_MAX)
      else $error("parameter type out of range");

   chk_code_read: assert property ( // RL4
      i_rd && word_addr == AW'(`EDC_OFS_CODE) |=>
         o_rdata == $past({state_ff.msg.number, state_ff.msg.ptype}))
      else $error("code word read wrong");

   chk_msg_together: assert property ( // RL22
      $changed(state_ff.msg.number) || $changed(state_ff.msg.param1) |-> o_msg_update)
      else $error("message words changed apart");

   cov_general: cover property (i_err_valid && msg_en ##1 o_msg_update);
   cov_parity: cover property (i_memory_parity_error && addr_en ##1 state_ff.pe_seen);
   cov_timeout: cover property (i_bus_timeout_error ##1 state_ff.to_seen);
   cov_both: cover property (i_memory_parity_error && i_err_valid && msg_en);

endmodule // edc_capture

// ===== dv/tb_top.sv
// self-checking bench for the error diagnostic capture block
`timescale 1ns/1ps
`include "edc_map.svh"
module tb_top;

   // ------------------------------------------------------------
   // clock, reset and stimulus
   // ------------------------------------------------------------
   logic        i_clock;
   logic        i_nrst;
   logic [19:0] addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic        err_valid;
   logic [7:0]  err_number;
   logic [15:0] p1;
   logic [15:0] p2;
   logic [15:0] p3;
   logic        to_err;
   logic        to_user;
   logic [31:0] to_addr;
   logic        pe_err;
   logic [31:0] pe_addr;
   logic        msg_update;
   logic [2:0]  last_class;
   logic [15:0] code_tab [0:31];
   int          errors;
   int          samples_checked;

   edc_capture #(.AW(20)) edc_capture_i (
      .i_clock               (i_clock),
      .i_nrst                (i_nrst),
      .i_addr                (addr),
      .i_wdata               (wdata),
      .i_wr                  (wr),
      .i_rd                  (rd),
      .o_rdata               (rdata),
      .i_err_valid           (err_valid),
      .i_err_number          (err_number),
      .i_err_param1          (p1),
      .i_err_param2          (p2),
      .i_err_param3          (p3),
      .i_bus_timeout_error   (to_err),
      .i_bus_timeout_user    (to_user),
      .i_bus_timeout_addr    (to_addr),
      .i_memory_parity_error (pe_err),
      .i_parity_addr         (pe_addr),
      .o_msg_update          (msg_update),
      .o_last_class          (last_class)
   );

   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      if (errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic rd_chk(input string nm, input logic [19:0] a, input logic [15:0] exp);
      @(posedge i_clock);
      rd   <= 1'b1;
      addr <= a;
      @(posedge i_clock);
      rd <= 1'b0;
      #1;
      check(nm, rdata, exp);
   endtask

   task automatic wr_word(input logic [19:0] a, input logic [15:0] d);
      @(posedge i_clock);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge i_clock);
      wr <= 1'b0;
   endtask

   // which: bit0 general report, bit1 bus timeout, bit2 parity
   task automatic pulse(input logic [2:0] which, input logic user, input logic [7:0] n,
                        input logic [31:0] a, input logic exp_upd);
      @(posedge i_clock);
      err_valid  <= which[0];
      to_err     <= which[1];
      pe_err     <= which[2];
      to_user    <= user;
      err_number <= n;
      p1         <= {n, 8'hA5};
      p2         <= a[31:16];
      p3         <= a[15:0];
      to_addr    <= a;
      pe_addr    <= a;
      @(posedge i_clock);
      err_valid <= 1'b0;
      to_err    <= 1'b0;
      pe_err    <= 1'b0;
      #1;
      check("msg_update", {15'h0, msg_update}, {15'h0, exp_upd});
      @(posedge i_clock);
      #1;
      check("msg_update_end", {15'h0, msg_update}, 16'h0000);
   endtask

   function automatic logic [2:0] class_of(input logic [7:0] n);
      if (n >= 8'h01 && n <= 8'h2F) return 3'h1;
      if (n >= 8'h30 && n <= 8'h3F) return 3'h2;
      if (n == 8'h40) return 3'h3;
      if (n >= 8'h61 && n <= 8'h68) return 3'h4;
      return 3'h0;
   endfunction

   task automatic msg_chk(input logic [15:0] code, input logic [15:0] e1,
                          input logic [15:0] e2, input logic [15:0] e3);
      rd_chk("code_word", `EDC_OFS_CODE, code);
      rd_chk("param_one", `EDC_OFS_PARAM1, e1);
      rd_chk("param_two", `EDC_OFS_PARAM2, e2);
      rd_chk("param_three", `EDC_OFS_PARAM3, e3);
   endtask

   // ------------------------------------------------------------
   // watchdog
   // ------------------------------------------------------------
   // span is about forty times the expected run, so only a hang trips it
   initial begin
      repeat (20000) @(posedge i_clock);
      errors++;
      final_report();
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      logic [7:0]  n;
      logic [7:0]  pt;
      logic [31:0] a;
      logic [15:0] z1;
      errors = 0;
      samples_checked = 0;
      i_nrst = 1'b0;
      {addr, wdata, wr, rd, err_valid, err_number, p1, p2, p3} = '0;
      {to_err, to_user, to_addr, pe_err, pe_addr} = '0;
      code_tab = '{16'h0101, 16'h0201, 16'h0301, 16'h0801, 16'h0502, 16'h0603, 16'h1103,
                   16'h0904, 16'h0A05, 16'h2305, 16'h1601, 16'h1701, 16'h2701, 16'h1C08,
                   16'h1E00, 16'h2500, 16'h2600, 16'h2009, 16'h2109, 16'h2209, 16'h3000,
                   16'h3406, 16'h3607, 16'h3806, 16'h3E07, 16'h610B, 16'h630B, 16'h6600,
                   16'h6700, 16'h6800, 16'h0D07, 16'h4000};
      repeat (8) @(posedge i_clock);
      i_nrst <= 1'b1;
      // words clear after reset, unmapped place reads zero
      rd_chk("to_hi_rst", `EDC_OFS_TO_HI, 16'h0000);
      rd_chk("pe_lo_rst", `EDC_OFS_PE_LO, 16'h0000);
      msg_chk(16'h0000, 16'h0000, 16'h0000, 16'h0000);
      rd_chk("unmapped", 20'hEF048, 16'h0000);
      // code table with number high, type low
      for (int i = 0; i < 32; i++) begin
         n  = code_tab[i][15:8];
         pt = code_tab[i][7:0];
         a  = {16'h1200 + 16'(i), 16'hC300 + 16'(i)};
         z1 = (pt == 8'h00) ? 16'h0000 : {n, 8'hA5};
         pulse(3'b001, 1'b0, n, a, 1'b1);
         msg_chk(code_tab[i], z1, (pt == 8'h00) ? 16'h0000 : a[31:16],
                 (pt == 8'h00) ? 16'h0000 : a[15:0]);
         check("last_class", {13'h0, last_class}, {13'h0, class_of(n)});
      end
      // user memory timeout latches address and message
      pulse(3'b010, 1'b1, 8'h00, 32'hDEAD_BEEF, 1'b1);
      rd_chk("to_hi", `EDC_OFS_TO_HI, 16'hDEAD);
      rd_chk("to_lo", `EDC_OFS_TO_LO, 16'hBEEF);
      rd_chk("code_to", `EDC_OFS_CODE, 16'h0603);
      rd_chk("p2_to", `EDC_OFS_PARAM2, 16'hDEAD);
      rd_chk("p3_to", `EDC_OFS_PARAM3, 16'hBEEF);
      // non-user timeout only moves the address words
      pulse(3'b010, 1'b0, 8'h00, 32'h0102_0304, 1'b0);
      rd_chk("to_hi2", `EDC_OFS_TO_HI, 16'h0102);
      rd_chk("to_lo2", `EDC_OFS_TO_LO, 16'h0304);
      rd_chk("code_kept", `EDC_OFS_CODE, 16'h0603);
      // parity beats a same-cycle report, all words replaced
      pulse(3'b101, 1'b0, 8'h09, 32'h1234_5678, 1'b1);
      rd_chk("pe_hi", `EDC_OFS_PE_HI, 16'h1234);
      rd_chk("pe_lo", `EDC_OFS_PE_LO, 16'h5678);
      msg_chk(16'h1103, 16'h0000, 16'h1234, 16'h5678);
      // read-only words ignore writes
      wr_word(`EDC_OFS_CODE, 16'hFFFF);
      wr_word(`EDC_OFS_PE_HI, 16'hFFFF);
      rd_chk("code_ro", `EDC_OFS_CODE, 16'h1103);
      rd_chk("pe_hi_ro", `EDC_OFS_PE_HI, 16'h1234);
      // message capture off: report refused, then back on
      rd_chk("ctrl_rst", `EDC_OFS_CTRL, 16'h0003);
      wr_word(`EDC_OFS_CTRL, 16'h0002);
      pulse(3'b001, 1'b0, 8'h16, 32'h0, 1'b0);
      rd_chk("code_off", `EDC_OFS_CODE, 16'h1103);
      wr_word(`EDC_OFS_CTRL, 16'h0003);
      // two reports two idle cycles apart keep only the latest
      pulse(3'b001, 1'b0, 8'h16, 32'hAAAA_5555, 1'b1);
      pulse(3'b001, 1'b0, 8'h27, 32'h3333_4444, 1'b1);
      msg_chk(16'h2701, 16'h27A5, 16'h3333, 16'h4444);
      // status flags, read data idle, write-one clear
      rd_chk("status_set", `EDC_OFS_STATUS, 16'h0701);
      @(posedge i_clock);
      #1;
      check("rdata_idle", rdata, 16'h0000);
      wr_word(`EDC_OFS_STATUS, 16'h0700);
      rd_chk("status_clr", `EDC_OFS_STATUS, 16'h0001);
      // unknown number gets type 00 and zero parameters
      pulse(3'b001, 1'b0, 8'h00, 32'h5A5A_A5A5, 1'b1);
      msg_chk(16'h0000, 16'h0000, 16'h0000, 16'h0000);
      rd_chk("status_unk", `EDC_OFS_STATUS, 16'h0410);
      // address capture off: words kept, message still written
      wr_word(`EDC_OFS_CTRL, 16'h0001);
      pulse(3'b100, 1'b0, 8'h00, 32'h7777_8888, 1'b1);
      rd_chk("pe_hi_off", `EDC_OFS_PE_HI, 16'h1234);
      msg_chk(16'h1103, 16'h0000, 16'h7777, 16'h8888);
      final_report();
   end

endmodule // tb_top
